// >>> rtl/uotg_ms_timer.sv
`default_nettype none
module uotg_ms_timer #(
  parameter int unsigned CYCLES = uotg_pkg::MS_CYCLES
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic run,
  input wire logic restart,
  output logic expired
);
  localparam int unsigned CW = $clog2(CYCLES + 1);
  logic [CW-1:0] count_r;
  logic [CW-1:0] count_nxt;
  logic expired_nxt;

  always_comb begin
    count_nxt = count_r + 1'b1;
    expired_nxt = 1'b0;
    if (restart || !run) begin
      count_nxt = '0;
    end else if (count_r == CW'(CYCLES - 1)) begin
      count_nxt = '0;
      expired_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      count_r <= '0;
      expired <= 1'b0;
    end else begin
      count_r <= count_nxt;
      expired <= expired_nxt;
    end
  end
endmodule : uotg_ms_timer
`default_nettype wire

// >>> rtl/uotg_pkg.sv
`default_nettype none
package uotg_pkg;
  localparam int unsigned AXI_ADDR_W = 8;
  // register byte offsets
  localparam logic [7:0] OFS_BUS_ADDRESS = 8'h00;
  localparam logic [7:0] OFS_TOKEN = 8'h04;
  localparam logic [7:0] OFS_THRESHOLD = 8'h08;
  localparam logic [7:0] OFS_CONFIG_ONE = 8'h0c;
  localparam logic [7:0] OFS_CONFIG_TWO = 8'h10;
  localparam logic [7:0] OFS_OTG_FLAGS = 8'h14;
  localparam logic [7:0] OFS_OTG_ENABLES = 8'h18;
  localparam logic [7:0] OFS_PERIPH_FLAGS = 8'h1c;
  localparam logic [7:0] OFS_POWER = 8'h20;
  localparam logic [7:0] OFS_LIVE_STATUS = 8'h24;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // field positions
  localparam int LOW_SPEED_BIT = 7;
  localparam int EYE_TEST_BIT = 7;
  localparam int DRIVE_MON_BIT = 6;
  localparam int IDLE_STOP_BIT = 4;
  localparam int CMP_SEL_BIT = 5;
  localparam int VBUS_PU_BIT = 4;
  localparam int EXT_SERIAL_BIT = 3;
  localparam int BOOST_DIS_BIT = 2;
  localparam int CMP_DIS_BIT = 1;
  localparam int XCVR_DIS_BIT = 0;
  localparam int POWER_EN_BIT = 0;
  localparam int ID_BIT = 7;
  localparam int MS_BIT = 6;
  localparam int LINE_BIT = 5;
  localparam int ACT_BIT = 4;
  localparam int SESSV_BIT = 3;
  localparam int SESSION_END_PIN_BIT = 2;
  localparam int VBUSV_BIT = 0;
  localparam logic [7:0] OTG_FLAG_MASK = 8'hfd;
  localparam logic [7:0] CFG1_MASK = 8'hd3;
  localparam logic [7:0] CFG2_MASK = 8'h3f;
  localparam logic [7:0] PERIPH_RO_MASK = 8'h02;
  // token types and ping-pong modes
  localparam logic [3:0] TOKEN_OUT = 4'h1;
  localparam logic [3:0] TOKEN_IN = 4'h9;
  localparam logic [3:0] TOKEN_SETUP = 4'hd;
  localparam logic [1:0] PP_NONE = 2'h0;
  localparam logic [1:0] PP_EP0_OUT = 2'h1;
  localparam logic [1:0] PP_ALL = 2'h2;
  localparam logic [1:0] PP_NOT_EP0 = 2'h3;
  localparam logic [7:0] THRESHOLD_OVERHEAD = 8'h0a;
  // timing
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned MS_TIME_NS = 1000000;
  localparam int unsigned MS_CYCLES = MS_TIME_NS / CLK_PERIOD_NS;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic vbus_valid;
    logic session_valid;
    logic session_end;
  } uotg_vbus_t;

  typedef struct packed {
    logic live_j_indication;
    logic se0;
  } uotg_line_t;

  typedef struct packed {
    logic frame_threshold_hit;
    logic low_speed_select;
    logic eye_test_active;
    logic module_run;
    logic pp_ep0_out;
    logic pp_ep0_in;
    logic pp_epn;
    logic vbus_pullup_enable;
    logic external_ctrl_over_serial;
    logic ext_ctrl_pins_en;
    logic boost_onchip_en;
    logic boost_ext_ctrl_en;
    logic comparator_onchip_en;
    logic comparator_ext_en;
    logic transceiver_onchip_en;
    logic transceiver_ext_en;
  } uotg_ctl_t;
endpackage : uotg_pkg
`default_nettype wire

// >>> rtl/uotg_regs.sv
`default_nettype none
// Overview of operation
// [R1] address holds 7-bit bus address; bit 7 low speed, host mode only
// [R2] token type 1101 setup, 1001 in, 0001 out, issued in host mode
// [R3] software writes only the three defined token type codes
// [R4] software loads an endpoint that exists on the attached peripheral
// [R5] frame threshold is ten plus max packet size; sets threshold hit
// [R6] eye test bit set drives the eye-pattern test
// [R7] monitor bit with transceiver disabled gives active-low drive enable
// [R8] stop-in-idle bit halts the controller while processor idles
// [R9] ping-pong field: 11 ep1-15, 10 all, 01 ep0 out, 00 none
// [R10] select bit picks three vbus pins, else two encoded pins
// [R11] external control goes over serial bus when set, pins when clear
// [R12] boost disable turns on-chip boost off, external output on
// [R13] comparator disable turns on-chip comparator off, external pins on
// [R14] transceiver disable turns on-chip transceiver off, external on
// [R15] software keeps the three disable bits while power is on
// [R16] in host mode an id pin change sets the id flag
// [R17] every 1 ms timer expiry sets the timer flag
// [R18] line state stable 1 ms and new sets the line flag
// [R19] any d+/d- or vbus activity sets the activity flag
// [R20] each vbus threshold crossing, either way, sets its flag
// [R21] flags clear where a one is written; an event beats the clear
// [R22] each enable bit lets its flag raise the interrupt
// [R23] power enable bit turns the controller on; resets to zero
// [R24] j state is differential 0 low speed, 1 full speed
// [R25] interrupt asserted while any flag and its enable are set
// [R26] all bits reset to zero; upper byte reads zero
module uotg_regs #(
  parameter int unsigned MS_CYCLES = uotg_pkg::MS_CYCLES
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [uotg_pkg::AXI_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [uotg_pkg::AXI_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic host_mode,
  input wire logic cpu_idle,
  input wire logic xcvr_driving,
  input wire logic [7:0] frame_bytes_left,
  input wire logic [7:0] periph_events,
  input wire logic id_pin,
  input wire logic dp_pin,
  input wire logic dm_pin,
  input wire uotg_pkg::uotg_vbus_t onchip_vbus,
  input wire logic vbus_valid_pin,
  input wire logic session_valid_pin,
  input wire logic session_end_pin,
  input wire logic comparator_status_pin_a,
  input wire logic comparator_status_pin_b,
  output logic [6:0] bus_address,
  output logic token_start,
  output logic [3:0] token_type_field,
  output logic [3:0] token_endpoint_field,
  output uotg_pkg::uotg_ctl_t ctl,
  output logic xcvr_oe_n,
  output logic otg_irq
);
  logic [10:0] raw_in;
  logic [10:0] sync_in;
  logic id_s;
  logic dp_s;
  logic dm_s;
  uotg_pkg::uotg_vbus_t onchip_s;
  uotg_pkg::uotg_vbus_t ext3_s;
  uotg_pkg::uotg_vbus_t vbus_now;
  uotg_pkg::uotg_vbus_t vbus_prev_r;
  uotg_pkg::uotg_line_t line_now;
  uotg_pkg::uotg_line_t line_prev_r;
  uotg_pkg::uotg_line_t line_rec_r;
  uotg_pkg::uotg_line_t line_rec_nxt;
  uotg_pkg::uotg_ctl_t ctl_nxt;
  logic [7:0] addr_r, addr_nxt, token_r, token_nxt, thresh_r, thresh_nxt;
  logic [7:0] cfg1_r, cfg1_nxt, cfg2_r, cfg2_nxt;
  logic [7:0] oflags_r, oflags_nxt, oen_r, oen_nxt, pflags_r, pflags_nxt;
  logic [7:0] oevt, oclr, pclr;
  logic power_r, power_nxt;
  logic id_prev_r;
  logic [1:0] dpdm_prev_r;
  logic module_run, low_speed, ms_tick, stable_tick, line_change;
  logic token_start_nxt, xcvr_oe_n_nxt;
  logic wr_go, wr_lo, rd_go, wr_hit, rd_hit;
  logic [7:0] wr_ofs, rd_ofs, rbyte;
  logic bvalid_nxt, rvalid_nxt;
  logic [1:0] bresp_nxt, rresp_nxt;
  logic [31:0] rdata_nxt;

  function automatic logic ofs_hit(input logic [7:0] o);
    return o inside {uotg_pkg::OFS_BUS_ADDRESS, uotg_pkg::OFS_TOKEN,
      uotg_pkg::OFS_THRESHOLD, uotg_pkg::OFS_CONFIG_ONE,
      uotg_pkg::OFS_CONFIG_TWO, uotg_pkg::OFS_OTG_FLAGS,
      uotg_pkg::OFS_OTG_ENABLES, uotg_pkg::OFS_PERIPH_FLAGS,
      uotg_pkg::OFS_POWER, uotg_pkg::OFS_LIVE_STATUS};
  endfunction : ofs_hit

  // pins from outside the clock domain
  assign raw_in = {id_pin, dp_pin, dm_pin, onchip_vbus, vbus_valid_pin,
    session_valid_pin, session_end_pin, comparator_status_pin_a,
    comparator_status_pin_b};

  uotg_sync #(.WIDTH(11)) u_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .din(raw_in),
    .dout(sync_in)
  );

  assign id_s = sync_in[10];
  assign dp_s = sync_in[9];
  assign dm_s = sync_in[8];
  assign onchip_s = sync_in[7:5];
  assign ext3_s = sync_in[4:2];

  // bus slave: address and data taken together, one answer outstanding
  assign wr_go = awvalid & wvalid & ~bvalid;
  assign awready = wr_go;
  assign wready = wr_go;
  assign rd_go = arvalid & ~rvalid;
  assign arready = rd_go;
  assign wr_ofs = {awaddr[7:2], 2'b00};
  assign rd_ofs = {araddr[7:2], 2'b00};
  assign wr_hit = ofs_hit(wr_ofs);
  assign rd_hit = ofs_hit(rd_ofs);
  assign wr_lo = wr_go & wstrb[0];

  assign module_run = power_r & ~(cfg1_r[uotg_pkg::IDLE_STOP_BIT] & cpu_idle); // [R8] [R23]
  assign low_speed = addr_r[uotg_pkg::LOW_SPEED_BIT] & host_mode; // [R1]

  uotg_ms_timer #(.CYCLES(MS_CYCLES)) u_ms (
    .core_clk(core_clk),
    .resetn(resetn),
    .run(module_run),
    .restart(1'b0),
    .expired(ms_tick)
  );

  // restarted on every line change, so it expires only after 1 ms stable
  uotg_ms_timer #(.CYCLES(MS_CYCLES)) u_stable (
    .core_clk(core_clk),
    .resetn(resetn),
    .run(module_run),
    .restart(line_change),
    .expired(stable_tick)
  );

  always_comb begin
    line_now.se0 = ~dp_s & ~dm_s;
    line_now.live_j_indication = low_speed ? (~dp_s & dm_s) : (dp_s & ~dm_s); // [R24]
    line_change = line_now != line_prev_r;
    // the two-pin form is coarse: it cannot say session end and valid apart
    if (!cfg2_r[uotg_pkg::CMP_DIS_BIT]) begin
      vbus_now = onchip_s; // [R13]
    end else if (cfg2_r[uotg_pkg::CMP_SEL_BIT]) begin
      vbus_now = ext3_s; // [R10]
    end else begin
      vbus_now.vbus_valid = sync_in[1] & sync_in[0]; // [R10]
      vbus_now.session_valid = sync_in[1] | sync_in[0];
      vbus_now.session_end = ~sync_in[1] & ~sync_in[0];
    end
  end

  always_comb begin
    oevt = '0;
    oevt[uotg_pkg::ID_BIT] = host_mode & (id_s != id_prev_r); // [R16]
    oevt[uotg_pkg::MS_BIT] = ms_tick; // [R17]
    oevt[uotg_pkg::LINE_BIT] = stable_tick & (line_now != line_rec_r); // [R18]
    oevt[uotg_pkg::ACT_BIT] = ({dp_s, dm_s} != dpdm_prev_r) |
      (vbus_now != vbus_prev_r); // [R19]
    oevt[uotg_pkg::SESSV_BIT] =
      vbus_now.session_valid ^ vbus_prev_r.session_valid; // [R20]
    oevt[uotg_pkg::SESSION_END_PIN_BIT] =
      vbus_now.session_end ^ vbus_prev_r.session_end; // [R20]
    oevt[uotg_pkg::VBUSV_BIT] =
      vbus_now.vbus_valid ^ vbus_prev_r.vbus_valid; // [R20]
    oevt = oevt & {8{module_run}};
    line_rec_nxt = stable_tick ? line_now : line_rec_r; // [R18]
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      id_prev_r <= 1'b0;
      dpdm_prev_r <= 2'b00;
      line_prev_r <= '0;
      line_rec_r <= '0;
      vbus_prev_r <= '0;
    end else begin
      id_prev_r <= id_s;
      dpdm_prev_r <= {dp_s, dm_s};
      line_prev_r <= line_now;
      line_rec_r <= line_rec_nxt;
      vbus_prev_r <= vbus_now;
    end
  end

  // register file
  always_comb begin
    addr_nxt = addr_r;
    token_nxt = token_r;
    thresh_nxt = thresh_r;
    cfg1_nxt = cfg1_r;
    cfg2_nxt = cfg2_r;
    oen_nxt = oen_r;
    power_nxt = power_r;
    oclr = '0;
    pclr = '0;
    token_start_nxt = 1'b0;
    if (wr_lo) begin
      unique case (wr_ofs)
        uotg_pkg::OFS_BUS_ADDRESS:
          addr_nxt = {host_mode & wdata[7], wdata[6:0]}; // [R1]
        uotg_pkg::OFS_TOKEN: begin
          token_nxt = wdata[7:0];
          token_start_nxt = host_mode; // [R2]
        end
        uotg_pkg::OFS_THRESHOLD: thresh_nxt = wdata[7:0];
        uotg_pkg::OFS_CONFIG_ONE: cfg1_nxt = wdata[7:0] & uotg_pkg::CFG1_MASK;
        uotg_pkg::OFS_CONFIG_TWO: cfg2_nxt = wdata[7:0] & uotg_pkg::CFG2_MASK;
        uotg_pkg::OFS_OTG_FLAGS: oclr = wdata[7:0]; // [R21]
        uotg_pkg::OFS_OTG_ENABLES:
          oen_nxt = wdata[7:0] & uotg_pkg::OTG_FLAG_MASK; // [R22]
        uotg_pkg::OFS_PERIPH_FLAGS:
          pclr = wdata[7:0] & ~uotg_pkg::PERIPH_RO_MASK;
        uotg_pkg::OFS_POWER: power_nxt = wdata[uotg_pkg::POWER_EN_BIT]; // [R23]
        default: ;
      endcase
    end
    // a new event in the clearing cycle survives
    oflags_nxt = ((oflags_r & ~oclr) | oevt) & uotg_pkg::OTG_FLAG_MASK; // [R21]
    pflags_nxt = (pflags_r & ~pclr) | periph_events;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      addr_r <= uotg_pkg::RESET_BYTE; // [R26]
      token_r <= uotg_pkg::RESET_BYTE;
      thresh_r <= uotg_pkg::RESET_BYTE;
      cfg1_r <= uotg_pkg::RESET_BYTE;
      cfg2_r <= uotg_pkg::RESET_BYTE;
      oflags_r <= uotg_pkg::RESET_BYTE;
      oen_r <= uotg_pkg::RESET_BYTE;
      pflags_r <= uotg_pkg::RESET_BYTE;
      power_r <= 1'b0; // [R23]
      token_start <= 1'b0;
    end else begin
      addr_r <= addr_nxt;
      token_r <= token_nxt;
      thresh_r <= thresh_nxt;
      cfg1_r <= cfg1_nxt;
      cfg2_r <= cfg2_nxt;
      oflags_r <= oflags_nxt;
      oen_r <= oen_nxt;
      pflags_r <= pflags_nxt;
      power_r <= power_nxt;
      token_start <= token_start_nxt;
    end
  end

  assign bus_address = addr_r[6:0];
  assign token_type_field = token_r[7:4]; // [R2]
  assign token_endpoint_field = token_r[3:0];
  assign otg_irq = |(oflags_r & oen_r); // [R22] [R25]

  // read mux and bus answers
  always_comb begin
    unique case (rd_ofs)
      uotg_pkg::OFS_BUS_ADDRESS: rbyte = {low_speed, addr_r[6:0]}; // [R1]
      uotg_pkg::OFS_TOKEN: rbyte = token_r;
      uotg_pkg::OFS_THRESHOLD: rbyte = thresh_r;
      uotg_pkg::OFS_CONFIG_ONE: rbyte = cfg1_r;
      uotg_pkg::OFS_CONFIG_TWO: rbyte = cfg2_r;
      uotg_pkg::OFS_OTG_FLAGS: rbyte = oflags_r;
      uotg_pkg::OFS_OTG_ENABLES: rbyte = oen_r;
      uotg_pkg::OFS_PERIPH_FLAGS: rbyte = pflags_r;
      uotg_pkg::OFS_POWER: rbyte = {7'h00, power_r};
      uotg_pkg::OFS_LIVE_STATUS:
        rbyte = {line_now, id_s, 2'b00, vbus_now}; // [R24]
      default: rbyte = uotg_pkg::RESET_BYTE;
    endcase
    rdata_nxt = rd_go ? {24'h000000, rbyte} : rdata; // [R26]
    rresp_nxt = rd_go ? (rd_hit ? uotg_pkg::RESP_OKAY : uotg_pkg::RESP_SLVERR)
      : rresp;
    rvalid_nxt = rd_go | (rvalid & ~rready);
    bresp_nxt = wr_go ? (wr_hit ? uotg_pkg::RESP_OKAY : uotg_pkg::RESP_SLVERR)
      : bresp;
    bvalid_nxt = wr_go | (bvalid & ~bready);
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= 32'h00000000;
      rresp <= uotg_pkg::RESP_OKAY;
      rvalid <= 1'b0;
      bresp <= uotg_pkg::RESP_OKAY;
      bvalid <= 1'b0;
    end else begin
      rdata <= rdata_nxt;
      rresp <= rresp_nxt;
      rvalid <= rvalid_nxt;
      bresp <= bresp_nxt;
      bvalid <= bvalid_nxt;
    end
  end

  // control outputs, registered so the pins never glitch
  always_comb begin
    ctl_nxt.frame_threshold_hit = frame_bytes_left <= thresh_r; // [R5]
    ctl_nxt.low_speed_select = low_speed; // [R1]
    ctl_nxt.eye_test_active = module_run & cfg1_r[uotg_pkg::EYE_TEST_BIT]; // [R6]
    ctl_nxt.module_run = module_run; // [R8]
    ctl_nxt.pp_ep0_out = cfg1_r[1:0] inside {uotg_pkg::PP_ALL,
      uotg_pkg::PP_EP0_OUT}; // [R9]
    ctl_nxt.pp_ep0_in = cfg1_r[1:0] == uotg_pkg::PP_ALL; // [R9]
    ctl_nxt.pp_epn = cfg1_r[1:0] inside {uotg_pkg::PP_ALL,
      uotg_pkg::PP_NOT_EP0}; // [R9]
    ctl_nxt.vbus_pullup_enable = cfg2_r[uotg_pkg::VBUS_PU_BIT];
    ctl_nxt.external_ctrl_over_serial = cfg2_r[uotg_pkg::EXT_SERIAL_BIT]; // [R11]
    ctl_nxt.ext_ctrl_pins_en = ~cfg2_r[uotg_pkg::EXT_SERIAL_BIT]; // [R11]
    ctl_nxt.boost_onchip_en = power_r & ~cfg2_r[uotg_pkg::BOOST_DIS_BIT]; // [R12]
    ctl_nxt.boost_ext_ctrl_en = power_r & cfg2_r[uotg_pkg::BOOST_DIS_BIT]; // [R12]
    ctl_nxt.comparator_onchip_en = power_r & ~cfg2_r[uotg_pkg::CMP_DIS_BIT]; // [R13]
    ctl_nxt.comparator_ext_en = power_r & cfg2_r[uotg_pkg::CMP_DIS_BIT]; // [R13]
    ctl_nxt.transceiver_onchip_en = power_r & ~cfg2_r[uotg_pkg::XCVR_DIS_BIT]; // [R14]
    ctl_nxt.transceiver_ext_en = power_r & cfg2_r[uotg_pkg::XCVR_DIS_BIT]; // [R14]
    xcvr_oe_n_nxt = ~(cfg1_r[uotg_pkg::DRIVE_MON_BIT] &
      cfg2_r[uotg_pkg::XCVR_DIS_BIT] & xcvr_driving); // [R7]
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctl <= '0;
      xcvr_oe_n <= 1'b1;
    end else begin
      ctl <= ctl_nxt;
      xcvr_oe_n <= xcvr_oe_n_nxt;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence tok_wr_s;
    wr_lo && wr_ofs == uotg_pkg::OFS_TOKEN && host_mode;
  endsequence
  sequence ms_clr_s;
    wr_lo && wr_ofs == uotg_pkg::OFS_OTG_FLAGS && wdata[uotg_pkg::MS_BIT];
  endsequence

  lowspd_device_a: assert property ( // [R1]
    !host_mode |=> !ctl.low_speed_select)
    else $error("low speed shown in device mode");
  token_issue_a: assert property ( // [R2]
    tok_wr_s |=> token_start && token_type_field == $past(wdata[7:4])
      && token_endpoint_field == $past(wdata[3:0]))
    else $error("token write did not issue");
  token_host_a: assert property ( // [R2]
    token_start |-> $past(host_mode))
    else $error("token issued outside host mode");
  thresh_hit_a: assert property ( // [R5]
    frame_bytes_left <= thresh_r |=> ctl.frame_threshold_hit)
    else $error("frame threshold missed");
  oe_monitor_a: assert property ( // [R7]
    !xcvr_oe_n |-> $past(cfg1_r[uotg_pkg::DRIVE_MON_BIT]
      && cfg2_r[uotg_pkg::XCVR_DIS_BIT] && xcvr_driving))
    else $error("drive enable without its conditions");
  idle_stop_a: assert property ( // [R8]
    cpu_idle && cfg1_r[uotg_pkg::IDLE_STOP_BIT] |=> !ctl.module_run)
    else $error("controller ran while idle");
  id_change_a: assert property ( // [R16]
    module_run && host_mode && id_s != id_prev_r
      |=> oflags_r[uotg_pkg::ID_BIT])
    else $error("id change not flagged");
  ms_flag_a: assert property ( // [R17]
    ms_tick |=> oflags_r[uotg_pkg::MS_BIT])
    else $error("timer expiry not flagged");
  vbus_cross_a: assert property ( // [R20]
    module_run && vbus_now.session_valid != vbus_prev_r.session_valid
      |=> oflags_r[uotg_pkg::SESSV_BIT])
    else $error("session crossing not flagged");
  flag_clear_a: assert property ( // [R21]
    ms_clr_s ##0 !ms_tick |=> !oflags_r[uotg_pkg::MS_BIT])
    else $error("written one did not clear flag");
  set_wins_a: assert property ( // [R21]
    ms_clr_s ##0 ms_tick |=> oflags_r[uotg_pkg::MS_BIT])
    else $error("event lost against clear");
  irq_raise_a: assert property ( // [R25]
    $rose(oflags_r[uotg_pkg::LINE_BIT]) && oen_r[uotg_pkg::LINE_BIT]
      |-> otg_irq)
    else $error("enabled flag raised no interrupt");
  power_off_a: assert property ( // [R23]
    !power_r [*2] |-> !ctl.module_run && !ctl.transceiver_onchip_en)
    else $error("controller on while power clear");
endmodule : uotg_regs
`default_nettype wire

// >>> rtl/uotg_sync.sv
`default_nettype none
module uotg_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  // first stage is read by the second stage only
  logic [WIDTH-1:0] meta_r;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
          meta_r[i] <= 1'b0;
          dout[i] <= 1'b0;
        end else begin
          meta_r[i] <= din[i];
          dout[i] <= meta_r[i];
        end
      end
    end
  endgenerate
endmodule : uotg_sync
`default_nettype wire

// >>> verification/test_usb_otg_config_and_otg_irq_regs.sv
`default_nettype none
module test_usb_otg_config_and_otg_irq_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'h0;
  logic resetn = 1'h0;
  logic [7:0] awaddr, araddr, frame_bytes_left;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, token_type_field, token_endpoint_field, ep;
  logic awvalid, wvalid, bready, arvalid, rready, host_mode, cpu_idle;
  logic xcvr_driving, idf, vbf, awready, wready, bvalid, arready, rvalid;
  logic token_start, xcvr_oe_n, otg_irq, id_pin;
  logic [1:0] bresp, rresp;
  logic [6:0] bus_address;
  logic [33:0] e;
  logic [3:0] codes[3] = '{uotg_pkg::TOKEN_SETUP, uotg_pkg::TOKEN_IN,
    uotg_pkg::TOKEN_OUT};
  logic [2:0] ppx[4] = '{3'h0, 3'h4, 3'h7, 3'h1};
  uotg_pkg::uotg_ctl_t ctl;
  uotg_pkg::uotg_vbus_t vb;
  logic [33:0] q[$];
  int failures = 0;
  int compares = 0;
  int tok = 0;
  always #2 core_clk = ~core_clk;
  // a short millisecond keeps the timer flag within reach of the run
  uotg_regs #(.MS_CYCLES(16)) dut (.core_clk, .resetn, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .host_mode, .cpu_idle, .xcvr_driving, .frame_bytes_left,
    .periph_events(8'h00), .id_pin, .dp_pin(1'h0), .dm_pin(1'h0),
    .onchip_vbus(vb), .vbus_valid_pin(vb.vbus_valid),
    .session_valid_pin(vb.session_valid), .session_end_pin(vb.session_end),
    .comparator_status_pin_a(vb.vbus_valid),
    .comparator_status_pin_b(vb.session_valid), .bus_address, .token_start,
    .token_type_field, .token_endpoint_field, .ctl, .xcvr_oe_n, .otg_irq);
  uotg_bus_peer peer (.core_clk, .id_flip(idf), .vbus_flip(vbf), .id_pin,
    .vbus(vb));
  task summarize;
    if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task settle;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
  endtask : settle
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    n = 0;
    do @(posedge core_clk); while (awready !== 1'h1 && ++n < 50);
    awvalid <= 1'h0;
    wvalid <= 1'h0;
    do @(posedge core_clk); while (bvalid !== 1'h1 && ++n < 50);
    bready <= 1'h0;
    chk({30'h0, bresp}, 32'h0);
    if (n >= 50) begin
      failures++;
      summarize();
    end
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    int n;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    n = 0;
    do @(posedge core_clk); while (arready !== 1'h1 && ++n < 50);
    arvalid <= 1'h0;
    q.push_back({r, d});
    do @(posedge core_clk); while (rvalid !== 1'h1 && ++n < 50);
    rready <= 1'h0;
    if (n >= 50) begin
      failures++;
      summarize();
    end
  endtask : rd
  always @(posedge core_clk) begin
    if (rvalid === 1'h1 && rready === 1'h1) begin
      e = q.pop_front();
      chk(rdata, e[31:0]);
      chk({30'h0, rresp}, {30'h0, e[33:32]});
    end
    if (token_start === 1'h1) tok++;
  end
  initial begin
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    {host_mode, cpu_idle, xcvr_driving, idf, vbf} = 5'h00;
    wstrb = 4'hf;
    frame_bytes_left = 8'hff;
    void'($urandom(32'h9d7e));
    repeat (8) @(posedge core_clk);
    resetn <= 1'h1;
    for (int i = 0; i < 9; i++) rd(8'(i * 4), 32'h0);
    rd(8'h28, 32'h0, 2'h2);
    wr(uotg_pkg::OFS_BUS_ADDRESS, 32'hff);
    rd(uotg_pkg::OFS_BUS_ADDRESS, 32'h7f);
    host_mode <= 1'h1;
    wr(uotg_pkg::OFS_BUS_ADDRESS, 32'hff);
    rd(uotg_pkg::OFS_BUS_ADDRESS, 32'hff);
    chk({25'h0, bus_address}, 32'h7f);
    for (int i = 0; i < 3; i++) begin
      ep = 4'($urandom);
      wr(uotg_pkg::OFS_TOKEN, {24'h0, codes[i], ep});
      @(negedge core_clk);
      chk({token_type_field, token_endpoint_field}, {codes[i], ep});
      chk(32'(tok), 32'(i + 1));
    end
    wr(uotg_pkg::OFS_THRESHOLD, 32'h4a);
    frame_bytes_left <= 8'h4a;
    settle;
    chk({31'h0, ctl.frame_threshold_hit}, 32'h1);
    @(posedge core_clk);
    frame_bytes_left <= 8'h4b;
    settle;
    chk({31'h0, ctl.frame_threshold_hit}, 32'h0);
    for (int p = 0; p < 4; p++) begin
      wr(uotg_pkg::OFS_CONFIG_ONE, 32'(p));
      settle;
      chk({ctl.pp_ep0_out, ctl.pp_ep0_in, ctl.pp_epn}, ppx[p]);
    end
    for (int v = 0; v < 8; v += 7) begin
      wr(uotg_pkg::OFS_CONFIG_TWO, 32'(v));
      settle;
      chk({26'h0, ctl[5:0]}, 32'h0);
    end
    wr(uotg_pkg::OFS_CONFIG_ONE, 32'hd0);
    xcvr_driving <= 1'h1;
    settle;
    chk({ctl.eye_test_active, xcvr_oe_n}, 32'h0);
    wr(uotg_pkg::OFS_POWER, 32'h1);
    settle;
    chk({31'h0, ctl.module_run}, 32'h1);
    chk({26'h0, ctl[5:0]}, 32'h15);
    chk({ctl.eye_test_active, xcvr_oe_n}, 32'h2);
    @(posedge core_clk);
    cpu_idle <= 1'h1;
    settle;
    chk({31'h0, ctl.module_run}, 32'h0);
    @(posedge core_clk);
    cpu_idle <= 1'h0;
    wr(uotg_pkg::OFS_OTG_ENABLES, 32'h80);
    repeat (20) @(posedge core_clk);
    chk({31'h0, otg_irq}, 32'h0);
    idf <= 1'h1;
    @(posedge core_clk);
    idf <= 1'h0;
    settle;
    chk({31'h0, otg_irq}, 32'h1);
    rd(uotg_pkg::OFS_OTG_FLAGS, 32'he0);
    wr(uotg_pkg::OFS_OTG_FLAGS, 32'h80);
    rd(uotg_pkg::OFS_OTG_FLAGS, 32'h60);
    chk({31'h0, otg_irq}, 32'h0);
    vbf <= 1'h1;
    @(posedge core_clk);
    vbf <= 1'h0;
    settle;
    rd(uotg_pkg::OFS_OTG_FLAGS, 32'h7d);
    wr(uotg_pkg::OFS_OTG_FLAGS, 32'h1d);
    rd(uotg_pkg::OFS_OTG_FLAGS, 32'h60);
    summarize();
  end
  initial begin
    #200000;
    failures++;
    summarize();
  end
endmodule : test_usb_otg_config_and_otg_irq_regs
`default_nettype wire

// >>> verification/uotg_bus_peer.sv
`default_nettype none
module uotg_bus_peer (
  input wire logic core_clk,
  input wire logic id_flip,
  input wire logic vbus_flip,
  output logic id_pin,
  output uotg_pkg::uotg_vbus_t vbus
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    id_pin = 1'h0;
    vbus = 3'h0;
  end
  // steps land just after an edge so the synchroniser sees a clean change
  always @(posedge core_clk) begin
    if (id_flip) id_pin <= ~id_pin;
    if (vbus_flip) vbus <= ~vbus;
  end
endmodule : uotg_bus_peer
`default_nettype wire
